// >>> rtl/spi_sel_pkg.sv
// Package: register offsets, field layouts and reset values of the
// serial master select/timing block.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
`default_nettype none
package spi_sel_pkg;
  // Register byte offsets
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] mode_off = 8'h04;
  localparam logic [7:0] rx_off = 8'h08;
  localparam logic [7:0] tx_off = 8'h0c;
  localparam logic [7:0] status_off = 8'h10;
  localparam logic [7:0] csr0_off = 8'h30;
  localparam logic [7:0] csr3_off = 8'h3c;
  // Control register fields
  localparam int ctrl_enable_bit = 0;
  localparam int ctrl_disable_bit = 1;
  localparam int ctrl_last_bit = 24;
  // Mode register fields
  localparam int mode_master_bit = 0;
  localparam int mode_psel_bit = 1;
  localparam int mode_dec_bit = 2;
  localparam int mode_cs_lsb = 16;
  localparam int mode_dly_lsb = 24;
  // Transmit word fields
  localparam int tx_cs_lsb = 16;
  localparam int tx_last_bit = 24;
  // Select config register fields
  localparam int csr_hold_bit = 3;
  localparam int csr_bits_lsb = 4;
  localparam int csr_div_lsb = 8;
  localparam int csr_pre_lsb = 16;
  localparam int csr_btw_lsb = 24;
  // Status bits
  localparam int st_tx_empty_bit = 1;
  localparam int st_rdrf_bit = 0;
  localparam int st_idle_bit = 9;
  localparam int st_en_bit = 16;
  // Reset values
  localparam logic [31:0] mode_reset = 32'h0000_0000;
  localparam logic [31:0] csr_reset = 32'h0000_0000;
  localparam logic [3:0] cs_idle = 4'hf;
  // Bits-per-word base: field value 0 means 8 bits
  localparam logic [4:0] bits_base = 5'h08;
  // AXI responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : spi_sel_pkg
`default_nettype wire

// >>> rtl/spi_sel_master.sv
// Master-mode serial engine: clock division, transfer delays and
// peripheral select logic behind an AXI4-Lite register slave.
// Assumes one clock aclk, synchronous active-low reset, inputs synchronous.
`timescale 1ns/100ps
`default_nettype none
module spi_sel_master #(
  parameter int ncs = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic serial_clock_pin,
  output logic mosi,
  input wire logic miso,
  output logic [3:0] select_lines
);
  if (ncs != 4) begin : g_ncs_check
    $error("ncs must be 4");
  end

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_cs_gap = 3'b001,
    st_pre = 3'b010,
    st_shift = 3'b011,
    st_between = 3'b100
  } state_e;

  state_e state_reg;
  logic [31:0] mode_reg;
  logic [31:0] csr_reg [ncs];
  logic enable_reg;
  logic [31:0] tdr_reg;
  logic tdr_full_reg;
  logic last_req_reg;
  logic [15:0] shift_reg;
  logic [15:0] rx_reg;
  logic rdrf_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] div_cnt_reg;
  logic [7:0] dly_cnt_reg;
  logic phase_reg;
  logic [3:0] cur_cs_reg;
  logic cur_last_reg;
  logic cs_active_reg;
  logic [3:0] select_reg;
  logic [3:0] last_cs_reg;
  logic sclk_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  // Write channel capture in either order
  wire aw_take = s_axi_awvalid && !aw_held_reg && !s_axi_bvalid;
  wire w_take = s_axi_wvalid && !w_held_reg && !s_axi_bvalid;
  wire wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_go = s_axi_arvalid && !s_axi_rvalid;

  // Register write decode
  wire [7:0] wa = awaddr_reg;
  wire wr_ctrl = wr_go && wa == spi_sel_pkg::ctrl_off;
  wire wr_mode = wr_go && wa == spi_sel_pkg::mode_off;
  wire wr_tx = wr_go && wa == spi_sel_pkg::tx_off;
  wire wr_csr = wr_go && wa >= spi_sel_pkg::csr0_off &&
    wa <= spi_sel_pkg::csr3_off && wa[1:0] == 2'h0;
  wire [1:0] wr_csr_idx = wa[3:2];
  wire wr_known = wr_ctrl || wr_mode || wr_tx || wr_csr ||
    wa == spi_sel_pkg::rx_off || wa == spi_sel_pkg::status_off;
  wire [31:0] mode_merged;
  generate
    for (genvar b = 0; b < 4; b++) begin : g_strb
      assign mode_merged[b*8 +: 8] = wstrb_reg[b] ?
        wdata_reg[b*8 +: 8] : mode_reg[b*8 +: 8];
    end
  endgenerate
  wire ctrl_en = wr_ctrl && wdata_reg[spi_sel_pkg::ctrl_enable_bit];
  wire ctrl_dis = wr_ctrl && wdata_reg[spi_sel_pkg::ctrl_disable_bit];
  wire ctrl_last = wr_ctrl && wdata_reg[spi_sel_pkg::ctrl_last_bit];

  // Mode fields
  wire psel = mode_reg[spi_sel_pkg::mode_psel_bit];
  wire decode_enable = mode_reg[spi_sel_pkg::mode_dec_bit];
  wire master = mode_reg[spi_sel_pkg::mode_master_bit];
  wire [3:0] mode_cs = mode_reg[spi_sel_pkg::mode_cs_lsb +: 4];
  wire [7:0] inter_select_delay = mode_reg[spi_sel_pkg::mode_dly_lsb +: 8];

  // Target select of the queued word
  wire [3:0] tx_cs = tdr_reg[spi_sel_pkg::tx_cs_lsb +: 4];
  wire [3:0] next_cs = psel ? tx_cs : mode_cs;
  wire next_last = tdr_reg[spi_sel_pkg::tx_last_bit] || last_req_reg;

  // Config register index from a select code
  function automatic logic [1:0] cfg_index(input logic [3:0] cs,
                                           input logic dec);
    logic [1:0] idx;
    idx = 2'h3;
    if (dec) begin
      idx = cs[3:2];
    end else if (!cs[0]) begin
      idx = 2'h0;
    end else if (!cs[1]) begin
      idx = 2'h1;
    end else if (!cs[2]) begin
      idx = 2'h2;
    end
    return idx;
  endfunction

  wire [1:0] cur_idx = cfg_index(cur_cs_reg, decode_enable);
  wire [1:0] nxt_idx = cfg_index(next_cs, decode_enable);
  wire [31:0] cur_csr = csr_reg[cur_idx];
  wire [31:0] nxt_csr = csr_reg[nxt_idx];
  wire [7:0] serial_clock_divisor = cur_csr[spi_sel_pkg::csr_div_lsb +: 8];
  wire [7:0] pre_clock_delay = nxt_csr[spi_sel_pkg::csr_pre_lsb +: 8];
  wire [7:0] between_transfers_delay = cur_csr[spi_sel_pkg::csr_btw_lsb +: 8];
  wire hold_select = cur_csr[spi_sel_pkg::csr_hold_bit];
  wire [4:0] nbits = spi_sel_pkg::bits_base +
    {1'b0, nxt_csr[spi_sel_pkg::csr_bits_lsb +: 4]};
  wire [4:0] nbits_cl = nbits > 5'h10 ? 5'h10 : nbits;

  // Decoded or one-hot select drive
  wire [3:0] onehot_n = ~(4'h1 << cfg_index(cur_cs_reg, 1'b0));
  wire [3:0] drive_sel = decode_enable ? cur_cs_reg : onehot_n;

  wire run = enable_reg && master;
  wire can_start = tdr_full_reg && run;
  wire div_tick = div_cnt_reg == 8'h00;
  wire dly_done = dly_cnt_reg == 8'h00;
  wire word_done = div_tick && phase_reg && bit_cnt_reg == 5'h01;
  wire transmitter_idle = state_reg == st_idle && !tdr_full_reg;
  wire [4:0] first_cnt = nbits_cl;
  wire [15:0] first_word = tdr_reg[15:0] << (5'h10 - nbits_cl);

  // Serial engine state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= st_idle;
      cs_active_reg <= 1'b0;
      cur_cs_reg <= spi_sel_pkg::cs_idle;
      last_cs_reg <= spi_sel_pkg::cs_idle;
      cur_last_reg <= 1'b0;
      dly_cnt_reg <= 8'h00;
      div_cnt_reg <= 8'h00;
      phase_reg <= 1'b0;
      bit_cnt_reg <= 5'h00;
      shift_reg <= 16'h0000;
      sclk_reg <= 1'b0;
      rx_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        st_idle: begin
          if (can_start) begin
            cur_cs_reg <= next_cs;
            cur_last_reg <= next_last;
            if (cs_active_reg && next_cs == cur_cs_reg) begin
              state_reg <= st_pre; // held select reused
              dly_cnt_reg <= pre_clock_delay;
            end else begin
              cs_active_reg <= 1'b0;
              state_reg <= st_cs_gap;
              dly_cnt_reg <= next_cs != last_cs_reg ?
                inter_select_delay : 8'h00;
            end
          end
        end
        st_cs_gap: begin
          if (dly_done) begin
            cs_active_reg <= 1'b1;
            last_cs_reg <= cur_cs_reg;
            dly_cnt_reg <= pre_clock_delay;
            state_reg <= st_pre;
          end else begin
            dly_cnt_reg <= dly_cnt_reg - 8'h01;
          end
        end
        st_pre: begin
          if (dly_done) begin
            shift_reg <= first_word;
            bit_cnt_reg <= first_cnt;
            div_cnt_reg <= serial_clock_divisor - 8'h01;
            phase_reg <= 1'b0;
            state_reg <= st_shift;
          end else begin
            dly_cnt_reg <= dly_cnt_reg - 8'h01;
          end
        end
        st_shift: begin
          if (div_tick) begin
            div_cnt_reg <= serial_clock_divisor - 8'h01;
            phase_reg <= !phase_reg;
            sclk_reg <= !phase_reg;
            if (!phase_reg) begin
              rx_reg <= {rx_reg[14:0], miso};
            end else begin
              shift_reg <= {shift_reg[14:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg - 5'h01;
            end
            if (word_done) begin
              dly_cnt_reg <= between_transfers_delay;
              state_reg <= st_between;
            end
          end else begin
            div_cnt_reg <= div_cnt_reg - 8'h01;
          end
        end
        st_between: begin
          if (dly_done) begin
            state_reg <= st_idle;
            if (cur_last_reg || (!hold_select &&
                !(can_start && next_cs == cur_cs_reg))) begin
              cs_active_reg <= 1'b0;
            end
          end else begin
            dly_cnt_reg <= dly_cnt_reg - 8'h01;
          end
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  // Holding register, last-transfer request and enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tdr_reg <= 32'h0000_0000;
      tdr_full_reg <= 1'b0;
      last_req_reg <= 1'b0;
      enable_reg <= 1'b0;
      rdrf_reg <= 1'b0;
    end else begin
      if (wr_tx) begin
        tdr_reg <= wdata_reg;
        tdr_full_reg <= 1'b1;
      end else if (state_reg == st_pre && dly_done) begin
        tdr_full_reg <= 1'b0;
      end
      if (ctrl_last) begin
        last_req_reg <= 1'b1;
      end else if (state_reg == st_idle && can_start) begin
        last_req_reg <= 1'b0;
      end
      if (ctrl_dis) begin
        enable_reg <= 1'b0;
      end else if (ctrl_en) begin
        enable_reg <= 1'b1;
      end
      if (state_reg == st_shift && word_done) begin
        rdrf_reg <= 1'b1;
      end else if (rd_go && s_axi_araddr == spi_sel_pkg::rx_off) begin
        rdrf_reg <= 1'b0;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= spi_sel_pkg::mode_reset;
      for (int i = 0; i < ncs; i++) begin
        csr_reg[i] <= spi_sel_pkg::csr_reset;
      end
    end else begin
      if (wr_mode) begin
        mode_reg <= mode_merged;
      end
      if (wr_csr) begin
        csr_reg[wr_csr_idx] <= wdata_reg;
      end
    end
  end

  // AXI write path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= spi_sel_pkg::resp_okay;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? spi_sel_pkg::resp_okay :
          spi_sel_pkg::resp_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data selection
  wire [7:0] ra = s_axi_araddr;
  wire [31:0] status_word = (32'h1 << spi_sel_pkg::st_tx_empty_bit) &
    {32{!tdr_full_reg}} |
    (32'h1 << spi_sel_pkg::st_rdrf_bit) & {32{rdrf_reg}} |
    (32'h1 << spi_sel_pkg::st_idle_bit) & {32{transmitter_idle}} |
    (32'h1 << spi_sel_pkg::st_en_bit) & {32{enable_reg}};
  wire rd_csr = ra >= spi_sel_pkg::csr0_off && ra <= spi_sel_pkg::csr3_off &&
    ra[1:0] == 2'h0;
  wire rd_known = ra == spi_sel_pkg::mode_off ||
    ra == spi_sel_pkg::rx_off || ra == spi_sel_pkg::status_off || rd_csr ||
    ra == spi_sel_pkg::ctrl_off || ra == spi_sel_pkg::tx_off;
  wire [31:0] rd_mux = ra == spi_sel_pkg::mode_off ? mode_reg :
    ra == spi_sel_pkg::rx_off ? {16'h0000, rx_reg} :
    ra == spi_sel_pkg::status_off ? status_word :
    rd_csr ? csr_reg[ra[3:2]] : 32'h0000_0000;

  // AXI read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= spi_sel_pkg::resp_okay;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_known ? spi_sel_pkg::resp_okay :
        spi_sel_pkg::resp_slverr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Pin drive from flip-flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      select_reg <= spi_sel_pkg::cs_idle;
    end else begin
      select_reg <= cs_active_reg ? drive_sel :
        spi_sel_pkg::cs_idle;
    end
  end
  assign select_lines = select_reg;
  assign serial_clock_pin = sclk_reg;
  assign mosi = shift_reg[15];
endmodule : spi_sel_master
`default_nettype wire

// >>> testbench/spi_sel_sva.sv
// Checker: bus answers and select/clock relations of the serial master.
// Assumes one clock aclk and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module spi_sel_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_clock_pin,
  input wire logic [3:0] select_lines
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Pins after reset and while clocking
  AST_RESET_IDLE: assert property (disable iff (1'b0)
    !aresetn |=> select_lines == 4'hf && !serial_clock_pin)
    else $error("select or clock active after reset");
  AST_CLOCK_NEEDS_SELECT: assert property (
    serial_clock_pin |-> select_lines != 4'hf)
    else $error("serial clock runs with no select");
  AST_SELECT_MOVES_CLOCK_LOW: assert property (
    select_lines != $past(select_lines) |-> !serial_clock_pin)
    else $error("select changed while serial clock high");
  // Bus answers stand and the read answer arrives on time
  AST_B_STANDS: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  AST_R_STANDS: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped early");
  AST_R_AFTER_AR: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_NO_AW_IN_B: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during answer");
  AST_NO_AR_IN_R: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during answer");
  cover property ($rose(serial_clock_pin));
  cover property (select_lines == 4'h5);
  cover property ($rose(select_lines[2]));
endmodule : spi_sel_sva
bind spi_sel_master spi_sel_sva u_spi_sel_sva (.*);
`default_nettype wire

// >>> testbench/spi_periph_model.sv
// Partner: serial peripheral on the select lines, clock mode 0.
// Assumes the serial clock is a register in the aclk domain.
`timescale 1ns/100ps
`default_nettype none
module spi_periph_model (
  input wire logic aclk,
  input wire logic serial_clock_pin,
  input wire logic mosi,
  input wire logic [3:0] select_lines,
  output logic miso,
  output logic [15:0] rx_word
);
  logic sclk_q = 1'b0;
  logic noise_q = 1'b0;
  logic [15:0] tx_q = 16'ha5c3;
  initial rx_word = 16'h0;
  // First bit out on selection, next bit as soon as the clock falls
  assign miso = (select_lines == 4'hf) ? noise_q :
    (!serial_clock_pin && sclk_q) ? tx_q[14] : tx_q[15];
  // Capture on rise, shift on fall, toggling noise when not selected
  always @(posedge aclk) begin
    sclk_q <= serial_clock_pin;
    if (select_lines == 4'hf) begin
      noise_q <= ~noise_q;
      tx_q <= 16'ha5c3;
    end else if (serial_clock_pin && !sclk_q) begin
      rx_word <= {rx_word[14:0], mosi};
    end else if (!serial_clock_pin && sclk_q) begin
      tx_q <= {tx_q[14:0], tx_q[15]};
    end
  end
endmodule : spi_periph_model
`default_nettype wire

// >>> testbench/testbench.sv
// Testbench: registers, select routing, clock division and select hold.
// Assumes the serial master and a peripheral model on its pins.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, sclk, mosi, miso, sclk_q;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, sel, sel_seen, code, prev_code;
  logic [1:0] bresp, rresp, r;
  logic [15:0] rx, m;
  int err_total, checks, rises, hi, hi_len, lead, dv[4], nb[4], pr[4];
  int gap, tail, mdly, ci;

  spi_sel_master u_spi_sel_master (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .serial_clock_pin(sclk),
    .mosi(mosi), .miso(miso), .select_lines(sel));
  spi_periph_model u_spi_periph_model (.aclk(aclk), .serial_clock_pin(sclk),
    .mosi(mosi), .select_lines(sel), .miso(miso), .rx_word(rx));

  // Clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Pin monitor; edge, lead, gap and select records cleared whenever a transmit word is offered
  always @(posedge aclk) begin
    sclk_q <= sclk;
    if (awvalid && awaddr == spi_sel_pkg::tx_off) begin
      rises <= 0;
      lead <= 0;
      gap <= 0;
      sel_seen <= 4'hf;
    end else begin
      if (sel != 4'hf) sel_seen <= sel;
      if (sel == 4'hf && sel_seen == 4'hf) gap <= gap + 1;
      if (sclk && !sclk_q) rises <= rises + 1;
      if (sel != 4'hf && rises == 0 && !sclk) lead <= lead + 1;
    end
    hi <= sclk ? hi + 1 : 0;
    if (sclk) begin
      tail <= 0;
    end else if (sel != 4'hf) begin
      tail <= tail + 1;
    end
    if (!sclk && sclk_q) hi_len <= hi;
  end

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic end_of_test;
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // A bounded wait ran out
  task automatic hang(input string nm);
    chk(nm, 32'h0, 32'h1);
    end_of_test();
  endtask : hang

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, got;
    got = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64 && !got; n++) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      got = bvalid;
      r = bresp;
      @(posedge aclk);
      awvalid <= awvalid & ~ta;
      wvalid <= wvalid & ~tw;
    end
    bready <= 1'b0;
    if (!got) hang("write answer");
  endtask : wr

  // Read: data and response land in d and r
  task automatic rd(input logic [7:0] a);
    logic ta, got;
    got = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64 && !got; n++) begin
      @(negedge aclk);
      ta = arready;
      got = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      arvalid <= arvalid & ~ta;
    end
    rready <= 1'b0;
    if (!got) hang("read answer");
  endtask : rd

  // Lowest line driven by a select code without decoding
  function automatic int low0(input logic [3:0] c);
    for (int i = 0; i < 4; i++) if (!c[i]) return i;
    return 0;
  endfunction : low0

  // Select config word from the chosen timing values
  function automatic logic [31:0] cfg(input int i, input logic h);
    return {8'(pr[i]), 8'(pr[i]), 8'(dv[i]), 4'(nb[i]), h, 3'h0};
  endfunction : cfg

  // One transmit word, then pin results against expectation
  task automatic xfer(input logic [31:0] w, input logic [3:0] es,
    input int i, input logic [3:0] ends);
    int bits;
    bits = nb[i] + 8;
    m = ~(16'hffff << bits);
    wr(spi_sel_pkg::tx_off, w);
    for (int n = 0; n < 2000 && rises < bits; n++) @(posedge aclk);
    if (rises < bits) hang("clock edges");
    d = 32'h0;
    for (int n = 0; n < 64 && !d[spi_sel_pkg::st_idle_bit]; n++) begin
      rd(spi_sel_pkg::status_off);
    end
    if (!d[spi_sel_pkg::st_idle_bit]) hang("idle flag");
    for (int n = 0; n < 64 && sel !== ends; n++) @(posedge aclk);
    chk("select seen", es, sel_seen);
    chk("clock edges", bits, rises);
    chk("clock high", dv[i], hi_len);
    chk("pre wait", 1, lead >= pr[i]);
    chk("data", w[15:0] & m, rx & m);
    chk("tx empty", 1, d[spi_sel_pkg::st_tx_empty_bit]);
    chk("end wait", 1, tail > pr[i]);
    chk("lines after", ends, sel);
  endtask : xfer

  // Main sequence
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    wstrb = 4'hf;
    void'($urandom(32'h52f6));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd((i == 5) ? 8'h20 : (i == 0) ? spi_sel_pkg::mode_off : 8'(44 + 4 * i));
      chk("reset value", 32'h0, d);
      chk("read response", (i == 5) ? 2'h2 : 2'h0, r);
    end
    wr(8'h20, 32'hffff_ffff);
    chk("write response", spi_sel_pkg::resp_slverr, r);
    wr(spi_sel_pkg::ctrl_off, 32'h1);
    for (int i = 0; i < 4; i++) begin
      dv[i] = 1 + $urandom % 4; // Never zero
      nb[i] = $urandom % 9;
      pr[i] = $urandom % 4;
      wr(8'(48 + 4 * i), cfg(i, 1'b0));
    end
    prev_code = spi_sel_pkg::cs_idle;
    // Fixed, variable and decoded selection in turn
    for (int k = 0; k < 12; k++) begin
      code = 4'($urandom % 15);
      mdly = $urandom % 32;
      ci = (k % 3 == 2) ? int'(code[3:2]) : low0(code);
      wr(spi_sel_pkg::mode_off, {8'(mdly), 4'h0, code, 13'h0,
        k % 3 == 2, k % 3 != 0, 1'b1});
      xfer({12'h0, (k % 3 != 0) ? code : ~code, 16'($urandom)},
        (k % 3 == 2) ? code : ~(4'h1 << low0(code)), ci, 4'hf);
      chk("select gap", 1, gap >= (code != prev_code ? mdly : 0));
      m = ~(16'hffff << (nb[ci] + 8));
      rd(spi_sel_pkg::rx_off);
      chk("rx data", 16'ha5c3 >> (8 - nb[ci]), d[15:0] & m);
      prev_code = code;
    end
    // Held select across words, released by the last-transfer request
    wr(8'h38, cfg(2, 1'b1));
    // Held line is two, the line that select code b drives low without decoding
    wr(spi_sel_pkg::mode_off, 32'h000b_0001);
    xfer(32'h0000_5a3c, 4'hb, 2, 4'hb);
    xfer(32'h0000_c3a5, 4'hb, 2, 4'hb);
    wr(spi_sel_pkg::ctrl_off, 32'h0100_0001);
    xfer(32'h0000_0ff0, 4'hb, 2, 4'hf);
    end_of_test();
  end

  // Run limit
  initial begin
    repeat (90000) @(posedge aclk);
    hang("run time");
  end
endmodule : testbench
`default_nettype wire
